// File: src/manual_word_aligner.sv
// Manual-mode 10-bit word aligner with output FIFO
`timescale 1ns/1ps
`default_nettype none
`include "word_align_defines.svh"

module word_fifo
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16,
    parameter int AW    = 4
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output var  logic             inReady,
    output var  logic [WIDTH-1:0] outData,
    output var  logic             outValid,
    input  wire logic             outReady
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;

    wire doWrite = inValid && inReady;
    wire doRead  = outValid && outReady;

    // Fill count after this cycle's write and read; empty comes from the count
    assign count_next = count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
    assign outValid   = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];

    // Storage write
    always_ff @(posedge sys_clk)
    begin
        if (doWrite)
            mem[wrPtr_reg] <= inData;
    end

    // Pointers, count and a registered not-full, so ready leaves from a flop
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            inReady   <= 1'b1;
        end
        else
        begin
            if (doWrite)
                wrPtr_reg <= wrPtr_reg + 1'b1;
            if (doRead)
                rdPtr_reg <= rdPtr_reg + 1'b1;
            count_reg <= count_next;
            inReady   <= (count_next < (AW+1)'(DEPTH));
        end
    end

    a_fifo_no_overflow: assert property (@(posedge sys_clk) disable iff (rst)
        count_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // word_fifo

module manual_word_aligner
    import word_align_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    input  wire word_t rxWord,
    input  wire logic  rxValid,
    output var  logic  rxReady,
    input  wire word_t alignPattern,
    input  wire logic  alignEnable,
    output logic       outValid_reg,
    output word_t      outData_reg,
    output logic       syncStatus_reg,
    output logic       patternDetect_reg,
    input  wire logic  outReady,
    output offset_t    boundary_reg,
    output logic       locked_reg
);
    word_t         prevWord_reg;
    word_t         curWord_reg;
    logic          curValid_reg;
    logic [19:0]   window;
    logic [9:0]    hitVec;
    offset_t       hitOffset;
    logic          anyHit;
    logic          newAlign;
    logic          sameHit;
    aligned_word_s stageWord;
    aligned_word_s fifoOut;
    logic          fifoValid;
    logic          fifoInReady;
    logic          outFree;
    logic          advance;
    align_state_e  state_reg;
    align_state_e  state_next;

    // Two-word window: older word in the high bits, as bits arrive
    assign window = {prevWord_reg, curWord_reg};

    // Compare the pattern at all ten offsets
    genvar g;
    generate
        for (g = 0; g < 10; g++)
        begin : g_cmp
            assign hitVec[g] = (window[19-g -: 10] == alignPattern);
        end
    endgenerate

    // Lowest-offset hit wins when several match
    always_comb
    begin
        hitOffset = `WA_OFFSET_RESET;
        for (int i = 9; i >= 0; i--)
        begin
            if (hitVec[i])
                hitOffset = 4'(i);
        end
    end

    assign anyHit  = curValid_reg && (hitVec != '0);
    assign sameHit = curValid_reg && locked_reg && hitVec[boundary_reg];
    assign newAlign = anyHit && alignEnable && !(sameHit && hitOffset == boundary_reg);

    // Stage word extracted at the locked (or freshly adopted) boundary
    assign stageWord.data          = window[19-(newAlign ? hitOffset : boundary_reg) -: 10];
    assign stageWord.syncStatus    = newAlign;
    assign stageWord.patternDetect = newAlign || sameHit;

    assign advance  = rxValid && fifoInReady;
    assign rxReady  = fifoInReady;
    assign outFree  = !outValid_reg || outReady;

    // Input shift: a stalled FIFO freezes the window
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prevWord_reg <= '0;
            curWord_reg  <= '0;
            curValid_reg <= 1'b0;
        end
        else if (advance)
        begin
            prevWord_reg <= curWord_reg;
            curWord_reg  <= rxWord;
            curValid_reg <= 1'b1;
        end
        else if (fifoInReady)
            curValid_reg <= 1'b0;
    end

    // Boundary holds unless enable lets a new pattern move it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            boundary_reg <= `WA_OFFSET_RESET;
            state_reg    <= ST_UNLOCKED;
            locked_reg   <= 1'b0;
        end
        else if (fifoInReady)
        begin
            if (newAlign)
                boundary_reg <= hitOffset;
            state_reg  <= state_next;
            locked_reg <= (state_next == ST_LOCKED);
        end
    end

    // Lock state: the first adopted boundary locks, only reset unlocks
    always_comb
    begin
        case (state_reg)
            ST_UNLOCKED: state_next = newAlign ? ST_LOCKED : ST_UNLOCKED;
            ST_LOCKED:   state_next = ST_LOCKED;
            default:     state_next = ST_UNLOCKED;
        endcase
    end

    // Data and flags share one path so latency is identical
    word_fifo #(
        .WIDTH ($bits(aligned_word_s)),
        .DEPTH (`WA_FIFO_DEPTH),
        .AW    (`WA_FIFO_PTR_WIDTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .inData   (stageWord),
        .inValid  (curValid_reg),
        .inReady  (fifoInReady),
        .outData  (fifoOut),
        .outValid (fifoValid),
        .outReady (outFree)
    );

    // Output register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            outValid_reg      <= 1'b0;
            outData_reg       <= '0;
            syncStatus_reg    <= 1'b0;
            patternDetect_reg <= 1'b0;
        end
        else if (outFree)
        begin
            outValid_reg      <= fifoValid;
            outData_reg       <= fifoOut.data;
            syncStatus_reg    <= fifoValid && fifoOut.syncStatus;
            patternDetect_reg <= fifoValid && fifoOut.patternDetect;
        end
    end

    // A new boundary adopted while the stage word goes into the buffer
    sequence s_adopt;
        newAlign && fifoInReady;
    endsequence

    a_sync_implies_detect: assert property (@(posedge sys_clk) disable iff (rst)
        syncStatus_reg |-> patternDetect_reg && outValid_reg) else $error("sync without detect");
    a_frozen_boundary: assert property (@(posedge sys_clk) disable iff (rst)
        !alignEnable |=> $stable(boundary_reg)) else $error("boundary moved while frozen");
    a_no_sync_frozen: assert property (@(posedge sys_clk) disable iff (rst)
        !alignEnable |-> !stageWord.syncStatus) else $error("sync while frozen");
    a_same_only_detect: assert property (@(posedge sys_clk) disable iff (rst)
        sameHit && !newAlign |-> stageWord.patternDetect && !stageWord.syncStatus)
        else $error("same boundary hit wrong flags");
    a_realign_taken: assert property (@(posedge sys_clk) disable iff (rst)
        s_adopt |=> boundary_reg == $past(hitOffset) && locked_reg)
        else $error("realign not taken");
    a_sync_pattern: assert property (@(posedge sys_clk) disable iff (rst)
        stageWord.syncStatus |-> stageWord.data == alignPattern) else $error("sync not on pattern");
    a_hit_offsets: assert property (@(posedge sys_clk) disable iff (rst)
        curValid_reg && window[19:10] == alignPattern |-> hitVec[0]) else $error("offset zero missed");
    a_flag_latency: assert property (@(posedge sys_clk) disable iff (rst)
        patternDetect_reg |-> outValid_reg) else $error("flag without data");
endmodule // manual_word_aligner
`default_nettype wire

// File: src/word_align_defines.svh
// Constants for the manual word aligner
`ifndef WORD_ALIGN_DEFINES_SVH
`define WORD_ALIGN_DEFINES_SVH

`define WA_WORD_WIDTH     10
`define WA_PATTERN_RESET  10'h17C
`define WA_OFFSET_RESET   4'h0
`define WA_FIFO_DEPTH     16
`define WA_FIFO_PTR_WIDTH 4

`endif

// File: src/word_align_pkg.sv
// Types shared by the manual word aligner
package word_align_pkg;

    typedef logic [9:0] word_t;
    typedef logic [3:0] offset_t;

    // One aligned word with its status flags
    typedef struct packed {
        word_t data;
        logic  syncStatus;
        logic  patternDetect;
    } aligned_word_s;

    typedef enum logic [1:0] {
        ST_UNLOCKED = 2'b00,
        ST_LOCKED   = 2'b01
    } align_state_e;

endpackage

// File: tb/fabric_sink.sv
// Fabric-side model that takes aligned words and steers align enable
`timescale 1ns/1ps
`default_nettype none
module fabric_sink
    import word_align_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    input  wire logic  stall,
    input  wire logic  slow,
    input  wire logic  wantAlign,
    input  wire logic  freezeOnSync,
    input  wire logic  outValid_reg,
    input  wire word_t outData_reg,
    input  wire logic  syncStatus_reg,
    input  wire logic  patternDetect_reg,
    output logic       outReady,
    output logic       alignEnable
);
    word_t dataQ[$];
    word_t flagData;
    int    syncCnt = 0;
    int    detCnt  = 0;
    int    badCnt  = 0;
    logic  frozen;
    logic  take;
    assign take = outValid_reg & outReady;
    // Enable follows wantAlign; with freezeOnSync set it drops once a sync beat is taken
    assign alignEnable = wantAlign & ~frozen;
    // Take beats promptly or every other cycle, and log them
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            outReady <= 1'b0;
            frozen   <= 1'b0;
        end
        else
        begin
            outReady <= ~stall & ~(slow & outReady);
            frozen   <= wantAlign & (frozen | (take & syncStatus_reg & freezeOnSync));
            if (take)
            begin
                dataQ.push_back(outData_reg);
                if (syncStatus_reg || patternDetect_reg)
                    flagData = outData_reg;
                syncCnt += int'(syncStatus_reg & patternDetect_reg);
                detCnt  += int'(~syncStatus_reg & patternDetect_reg);
                badCnt  += int'(syncStatus_reg & ~patternDetect_reg);
            end
        end
    end
endmodule // fabric_sink
`default_nettype wire

// File: tb/tb_manual_word_aligner.sv
// Self-checking bench for the manual word aligner
`timescale 1ns/1ps
`default_nettype none
module tb_manual_word_aligner
    import word_align_pkg::*;
;
    localparam word_t PAT = 10'h17C;
    localparam word_t HI  = 10'h02F;
    localparam word_t LO  = 10'h200;
    localparam word_t ALT = 10'h283;
    logic  sys_clk = 1'b0, rst = 1'b1, rxValid = 1'b0, stall = 1'b0, slow = 1'b0;
    logic  wantAlign = 1'b0, freezeOnSync = 1'b0, rxReady, outValid_reg, syncStatus_reg;
    logic  patternDetect_reg, outReady, alignEnable, locked_reg;
    word_t rxWord = 10'h000, outData_reg;
    word_t pattern = PAT;
    offset_t boundary_reg;
    int    n_errors = 0, cmp_count = 0, cycles = 0, sent = 0;
    manual_word_aligner dut_u (.sys_clk, .rst, .rxWord, .rxValid, .rxReady, .alignPattern(pattern),
        .alignEnable, .outValid_reg, .outData_reg, .syncStatus_reg, .patternDetect_reg, .outReady,
        .boundary_reg, .locked_reg);
    fabric_sink fab_u (.sys_clk, .rst, .stall, .slow, .wantAlign, .freezeOnSync, .outValid_reg,
        .outData_reg, .syncStatus_reg, .patternDetect_reg, .outReady, .alignEnable);
    always #20 sys_clk = ~sys_clk;
    // Cut a hung run short
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            results();
        end
    end
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string what, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task send(input word_t w);
        logic ok;
        rxWord  <= w;
        rxValid <= 1'b1;
        do
        begin
            @(negedge sys_clk) ok = rxReady;
            @(posedge sys_clk);
        end while (!ok);
    endtask
    task drain;
        @(posedge sys_clk);
        for (int i = 0; i < 300 && fab_u.dataQ.size() < sent; i++)
            @(posedge sys_clk);
    endtask
    task run(input word_t w[$], input int ds, input int dd, input offset_t bnd);
        int s0;
        int d0;
        s0 = fab_u.syncCnt;
        d0 = fab_u.detCnt;
        foreach (w[i])
            send(w[i]);
        rxValid <= 1'b0;
        sent += w.size();
        drain();
        chk("sync beats", 10'(ds), 10'(fab_u.syncCnt - s0));
        chk("detect beats", 10'(dd), 10'(fab_u.detCnt - d0));
        chk("lone sync", 10'h000, 10'(fab_u.badCnt));
        chk("boundary", 10'(bnd), 10'(boundary_reg));
    endtask
    // Fill the buffer against a stalled sink, then drain it slowly
    task fill_drain;
        int k;
        logic ok;
        stall   <= 1'b1;
        rxValid <= 1'b1;
        for (k = 1; k < 30; k++)
        begin
            rxWord <= word_t'(k);
            @(negedge sys_clk) ok = rxReady;
            @(posedge sys_clk);
            if (!ok)
                break;
        end
        rxValid <= 1'b0;
        stall   <= 1'b0;
        slow    <= 1'b1;
        chk("refusal point", 10'h001, 10'(k >= 17 && k < 30));
        sent = k - 1;
        drain();
        chk("drained count", 10'(sent), 10'(fab_u.dataQ.size()));
        // Offset zero hands out the older word, so the reset word leads
        foreach (fab_u.dataQ[i])
            chk("drained word", 10'(i), fab_u.dataQ[i]);
        slow <= 1'b0;
    endtask
    task align_first;
        wantAlign <= 1'b1;
        run('{10'h000, PAT, 10'h000, 10'h000}, 1, 0, 4'h0);
        chk("flagged word", PAT, fab_u.flagData);
        chk("locked", 10'h001, 10'(locked_reg));
    endtask
    task same_boundary;
        run('{PAT, 10'h000, 10'h000}, 0, 1, 4'h0);
    endtask
    task frozen_boundary;
        wantAlign <= 1'b0;
        run('{10'h000, HI, LO, 10'h000, 10'h000}, 0, 0, 4'h0);
        run('{PAT, 10'h000, 10'h000}, 0, 1, 4'h0);
    endtask
    task realign_offset;
        freezeOnSync <= 1'b1;
        wantAlign    <= 1'b1;
        run('{10'h000, HI, LO, 10'h000, 10'h000}, 1, 0, 4'h3);
        chk("flagged word", PAT, fab_u.flagData);
        run('{PAT, 10'h000, 10'h000}, 0, 0, 4'h3);
    endtask
    // A second programmed pattern moves a locked boundary back to offset zero
    task other_pattern;
        freezeOnSync <= 1'b0;
        wantAlign    <= 1'b0;
        pattern      <= ALT;
        @(posedge sys_clk);
        wantAlign <= 1'b1;
        run('{10'h000, ALT, 10'h000, 10'h000}, 1, 0, 4'h0);
        chk("flagged word", ALT, fab_u.flagData);
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        fill_drain();
        align_first();
        same_boundary();
        frozen_boundary();
        realign_offset();
        other_pattern();
        results();
    end
endmodule // tb_manual_word_aligner
`default_nettype wire
